// File: wit_cfg.svh
// Constants of the watch interval timer: offsets, fields, resets.
// Assumes a 32-bit APB with byte addresses of four times the index.
`ifndef WIT_CFG_SVH
`define WIT_CFG_SVH
// ----------------------------------------------------------------
// Register indices and address width
// ----------------------------------------------------------------
`define WIT_IDX_TCS    18'h0ff42
`define WIT_IDX_WMC    18'h0ff4a
`define WIT_IDX_STAT   18'h0ff50
`define WIT_IDX_CLR    18'h0ff51
`define WIT_IDX_EN     18'h0ff52
`define WIT_IDX_BIT    18'h0ff53
`define WIT_AW         18
// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define WIT_TCS_SRC    4
`define WIT_TCS_MASK   8'hf7
`define WIT_WMC_FAST   0
`define WIT_WMC_PRUN   1
`define WIT_WMC_CRUN   2
`define WIT_WMC_FSEL   3
`define WIT_WMC_IVLO   4
`define WIT_WMC_MASK   8'h7f
`define WIT_ST_TICK    0
`define WIT_ST_IVAL    1
// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define WIT_TCS_RST    8'h00
`define WIT_WMC_RST    8'h00
`define WIT_IV_BASE    4
`define WIT_IV_MAX     3'h5
`define WIT_FAST_BITS  5
`endif

// File: wit_pkg.sv
// Types of the watch interval timer.
// Holds its own interval codes; uses nothing from wit_cfg.svh.
package wit_pkg;
   typedef logic [7:0] wit_byte_t;
   typedef logic [1:0] wit_stat_t;
   typedef enum logic [2:0] {
      WIT_IV_4 = 3'h0,
      WIT_IV_5 = 3'h1,
      WIT_IV_6 = 3'h2,
      WIT_IV_7 = 3'h3,
      WIT_IV_8 = 3'h4,
      WIT_IV_9 = 3'h5
   } wit_ival_t;
endpackage

// File: wit_timer.sv
// Watch timer with interval timer, reached over APB.
// Assumes osc_tick and sub_tick are one-cycle pulses synchronous to
// pclk, one per oscillator and subsystem clock period.
//
// What this block does
// RULE_01 - Reset clears clock select register to zero
// RULE_02 - Watch clock: divided main or subsystem clock
// RULE_03 - Main clock is oscillator or oscillator half
// RULE_04 - Software stops timer before changing clock select
// RULE_05 - Clock select byte writes; mode allows bit writes
// RULE_06 - Reset clears watch mode control register
// RULE_07 - Interval codes pick 2^4 to 2^9 periods
// RULE_08 - Interval interrupt repeats without any reload
// RULE_09 - Flag period 2^14 or 2^13 watch periods
// RULE_10 - Fast feed sets flag every 2^5 periods
// RULE_11 - Counter run zero stops and clears counter
// RULE_12 - Prescaler run zero stops and clears prescaler
// RULE_13 - Each watch period sets the tick flag
// RULE_14 - Tick flag raises the standby wake request
// RULE_15 - Counter clear restarts the counter from zero; prescaler keeps its count
// RULE_16 - Software avoids frequent prescaler clears
// RULE_17 - Watch and interval functions run together
// RULE_18 - Binary prescaler feeds five-bit counter
`timescale 1ns/1ps
`include "wit_cfg.svh"

module wit_timer (
   // Clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [`WIT_AW-1:0]   paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Clock sources
   input  wire logic                 osc_tick,
   input  wire logic                 sub_tick,
   input  wire logic                 osc_mode_select,
   // Events
   output logic                      irq,
   output logic                      wake_req_q,
   output logic                      interval_irq_q
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   wit_pkg::wit_byte_t tcs_q;
   wit_pkg::wit_byte_t wmc_q;
   wit_pkg::wit_stat_t stat_q;
   wit_pkg::wit_stat_t en_q;
   logic [7:0]         osc_div_q;
   logic [8:0]         pre_q;
   logic [4:0]         cnt_q;

   logic               acc;
   logic               wr;
   logic [`WIT_AW-1:0] idx;
   logic               hit_tcs;
   logic               hit_wmc;
   logic               hit_stat;
   logic               hit_clr;
   logic               hit_en;
   logic               hit_bit;
   logic               mapped;
   logic               main_tick;
   logic               watch_tick;
   logic               pre_run;
   logic               cnt_run;
   logic               pre_ovf;
   logic               tick_ev;
   logic               ival_ev;
   wit_pkg::wit_ival_t ival;
   wit_pkg::wit_stat_t ev;
   wit_pkg::wit_stat_t clr;

   // True when the low n prescaler bits are all ones
   function automatic logic low_ones(input logic [8:0] v,
                                     input int unsigned n);
      logic r;
      r = 1'b1;
      for (int i = 0; i < 9; i++) begin
         if (i < n) begin
            r = r & v[i];
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   assign acc      = psel && penable;
   assign wr       = acc && pwrite;
   assign idx      = paddr >> 2;
   assign hit_tcs  = (idx == `WIT_IDX_TCS) && (paddr[1:0] == 2'h0);
   assign hit_wmc  = (idx == `WIT_IDX_WMC) && (paddr[1:0] == 2'h0);
   assign hit_stat = (idx == `WIT_IDX_STAT) && (paddr[1:0] == 2'h0);
   assign hit_clr  = (idx == `WIT_IDX_CLR) && (paddr[1:0] == 2'h0);
   assign hit_en   = (idx == `WIT_IDX_EN) && (paddr[1:0] == 2'h0);
   assign hit_bit  = (idx == `WIT_IDX_BIT) && (paddr[1:0] == 2'h0);
   assign mapped   = hit_tcs | hit_wmc | hit_stat | hit_clr | hit_en
                   | hit_bit;
   assign pready   = 1'b1;
   assign pslverr  = acc && !mapped;

   always_comb begin
      prdata = 32'h0000_0000;
      if (hit_tcs) begin
         prdata[7:0] = tcs_q;
      end else if (hit_wmc) begin
         prdata[7:0] = wmc_q;
      end else if (hit_stat) begin
         prdata[1:0] = stat_q;
      end else if (hit_en) begin
         prdata[1:0] = en_q;
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   // Clock select takes whole-byte writes only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tcs_q <= `WIT_TCS_RST; // see RULE_01
      end else if (wr && hit_tcs && pstrb[0]) begin
         tcs_q <= pwdata[7:0] & `WIT_TCS_MASK; // see RULE_05
      end
   end

   // Mode control takes a byte write or a single-bit write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wmc_q <= `WIT_WMC_RST; // see RULE_06
      end else if (wr && hit_wmc && pstrb[0]) begin
         wmc_q <= pwdata[7:0] & `WIT_WMC_MASK;
      end else if (wr && hit_bit && pstrb[0] && pwdata[2:0] != 3'h7) begin
         wmc_q[pwdata[2:0]] <= pwdata[3]; // see RULE_05
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= 2'h0;
      end else if (wr && hit_en && pstrb[0]) begin
         en_q <= pwdata[1:0];
      end
   end

   // ----------------------------------------------------------------
   // Clock sources
   // ----------------------------------------------------------------
   // Oscillator divider: 2^7 with undivided main clock, else 2^8
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_div_q <= 8'h00;
      end else if (osc_tick) begin
         osc_div_q <= osc_div_q + 8'h01;
      end
   end

   assign main_tick  = osc_tick && (osc_mode_select
                     ? (osc_div_q[6:0] == 7'h7f)
                     : (osc_div_q == 8'hff)); // see RULE_03
   assign watch_tick = tcs_q[`WIT_TCS_SRC] ? sub_tick
                     : main_tick; // see RULE_02

   // ----------------------------------------------------------------
   // Prescaler and five-bit counter
   // ----------------------------------------------------------------
   assign pre_run = wmc_q[`WIT_WMC_PRUN];
   assign cnt_run = wmc_q[`WIT_WMC_CRUN];
   assign pre_ovf = watch_tick && pre_run && (&pre_q); // see RULE_18

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q <= 9'h000;
      end else if (!pre_run) begin
         pre_q <= 9'h000; // see RULE_12
      end else if (watch_tick) begin
         pre_q <= pre_q + 9'h001; // see RULE_18
      end
   end

   // Clearing restarts the watch period, but the prescaler keeps its count, so the first period is short by that count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 5'h00;
      end else if (!cnt_run) begin
         cnt_q <= 5'h00; // see RULE_11, RULE_15
      end else if (pre_ovf) begin
         cnt_q <= cnt_q + 5'h01;
      end
   end

   // ----------------------------------------------------------------
   // Events
   // ----------------------------------------------------------------
   // Watch flag: fast feed, 2^13 or 2^14 watch periods
   always_comb begin
      if (wmc_q[`WIT_WMC_FAST]) begin
         tick_ev = watch_tick && pre_run
                 && low_ones(pre_q, `WIT_FAST_BITS); // see RULE_10
      end else if (wmc_q[`WIT_WMC_FSEL]) begin
         tick_ev = pre_ovf && cnt_run && (&cnt_q[3:0]); // see RULE_09
      end else begin
         tick_ev = pre_ovf && cnt_run && (&cnt_q); // see RULE_09
      end
   end

   // Interval taps share the prescaler with the watch function
   assign ival = wit_pkg::wit_ival_t'(wmc_q[`WIT_WMC_IVLO +: 3]);
   assign ival_ev = watch_tick && pre_run
                  && (wmc_q[`WIT_WMC_IVLO +: 3] <= `WIT_IV_MAX)
                  && low_ones(pre_q, `WIT_IV_BASE
                     + int'(ival)); // see RULE_07, RULE_08, RULE_17

   assign ev  = {ival_ev, tick_ev};
   assign clr = (wr && hit_clr && pstrb[0]) ? pwdata[1:0] : 2'h0;

   // Sticky status; a new event wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= 2'h0;
      end else begin
         stat_q <= (stat_q & ~clr) | ev; // see RULE_13
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_req_q     <= 1'b0;
         interval_irq_q <= 1'b0;
      end else begin
         wake_req_q     <= tick_ev; // see RULE_14
         interval_irq_q <= ival_ev; // see RULE_08
      end
   end

   assign irq = |(stat_q & en_q);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_pre_clear;
      @(posedge pclk) disable iff (!presetn)
      !pre_run |=> (pre_q == 9'h000);
   endproperty
   a_pre_clear: assert property (p_pre_clear) // see RULE_12
      else $error("prescaler not cleared while stopped");

   property p_cnt_clear;
      @(posedge pclk) disable iff (!presetn)
      !cnt_run ##1 !cnt_run |-> (cnt_q == 5'h00);
   endproperty
   a_cnt_clear: assert property (p_cnt_clear) // see RULE_11
      else $error("counter not cleared while stopped");

   property p_tick_sets;
      @(posedge pclk) disable iff (!presetn)
      tick_ev |=> stat_q[`WIT_ST_TICK] && wake_req_q;
   endproperty
   a_tick_sets: assert property (p_tick_sets) // see RULE_13
      else $error("watch tick did not set flag and wake");

   property p_fast_tap;
      @(posedge pclk) disable iff (!presetn)
      (tick_ev && wmc_q[`WIT_WMC_FAST]) |-> (pre_q[4:0] == 5'h1f);
   endproperty
   a_fast_tap: assert property (p_fast_tap) // see RULE_10
      else $error("fast feed flag off its tap");

   property p_long_tap;
      @(posedge pclk) disable iff (!presetn)
      (tick_ev && !wmc_q[`WIT_WMC_FAST] && !wmc_q[`WIT_WMC_FSEL])
         |-> (pre_q == 9'h1ff) && (cnt_q == 5'h1f);
   endproperty
   a_long_tap: assert property (p_long_tap) // see RULE_09
      else $error("long watch flag off the 2^14 tap");

   property p_short_tap;
      @(posedge pclk) disable iff (!presetn)
      (tick_ev && !wmc_q[`WIT_WMC_FAST] && wmc_q[`WIT_WMC_FSEL])
         |-> (pre_q == 9'h1ff) && (cnt_q[3:0] == 4'hf);
   endproperty
   a_short_tap: assert property (p_short_tap) // see RULE_09
      else $error("short watch flag off the 2^13 tap");

   property p_ival_sets;
      @(posedge pclk) disable iff (!presetn)
      ival_ev |=> stat_q[`WIT_ST_IVAL] && interval_irq_q;
   endproperty
   a_ival_sets: assert property (p_ival_sets) // see RULE_08
      else $error("interval event lost");

   property p_ival_bad;
      @(posedge pclk) disable iff (!presetn)
      (wmc_q[6:5] == 2'h3) |-> !ival_ev;
   endproperty
   a_ival_bad: assert property (p_ival_bad) // see RULE_07
      else $error("interval event from a prohibited code");

   property p_tcs_byte;
      @(posedge pclk) disable iff (!presetn)
      (wr && hit_tcs && !pstrb[0]) |=> $stable(tcs_q);
   endproperty
   a_tcs_byte: assert property (p_tcs_byte) // see RULE_05
      else $error("clock select changed without its byte lane");

   property p_src_sub;
      @(posedge pclk) disable iff (!presetn)
      (tcs_q[`WIT_TCS_SRC] && !sub_tick) |-> !watch_tick;
   endproperty
   a_src_sub: assert property (p_src_sub) // see RULE_02
      else $error("watch clock not from subsystem clock");

   property p_irq;
      @(posedge pclk) disable iff (!presetn)
      (stat_q[`WIT_ST_TICK] && en_q[`WIT_ST_TICK]) |-> irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("enabled status did not raise irq");

   property p_ival_top;
      @(posedge pclk) disable iff (!presetn)
      (ival_ev && (ival == wit_pkg::WIT_IV_9)) |-> (pre_q == 9'h1ff);
   endproperty
   a_ival_top: assert property (p_ival_top) // see RULE_07
      else $error("longest interval off the 2^9 tap");

   property p_pre_step;
      @(posedge pclk) disable iff (!presetn)
      (pre_run && watch_tick) |=> (pre_q == $past(pre_q) + 9'h001);
   endproperty
   a_pre_step: assert property (p_pre_step) // see RULE_18
      else $error("prescaler missed a watch clock");

   property p_cnt_step;
      @(posedge pclk) disable iff (!presetn)
      (cnt_run && pre_ovf) |=> (cnt_q == $past(cnt_q) + 5'h01);
   endproperty
   a_cnt_step: assert property (p_cnt_step) // see RULE_18
      else $error("counter missed a prescaler wrap");

   property p_src_main;
      @(posedge pclk) disable iff (!presetn)
      (!tcs_q[`WIT_TCS_SRC] && watch_tick) ##1 !tcs_q[`WIT_TCS_SRC]
         |-> !watch_tick;
   endproperty
   a_src_main: assert property (p_src_main) // see RULE_03
      else $error("divided main clock ticked twice in a row");

   property p_unmapped;
      @(posedge pclk) disable iff (!presetn)
      (wr && !mapped) |=> $stable(tcs_q) && $stable(wmc_q)
         && $stable(en_q);
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped write changed a register");

   property p_wmc_top;
      @(posedge pclk) disable iff (!presetn)
      !wmc_q[7];
   endproperty
   a_wmc_top: assert property (p_wmc_top)
      else $error("mode control bit 7 not zero");

   property p_stat_clear;
      @(posedge pclk) disable iff (!presetn)
      (clr[`WIT_ST_TICK] && !ev[`WIT_ST_TICK]) |=> !stat_q[`WIT_ST_TICK];
   endproperty
   a_stat_clear: assert property (p_stat_clear)
      else $error("tick status survived its clear");

endmodule

// File: watch_interval_timer_tb.sv
// Self-checking bench of the watch interval timer.
// Assumes wit_cfg.svh and wit_timer; ticks are pulsed every cycle.
`timescale 1ns/1ps
`include "wit_cfg.svh"

`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin \
   fail_count++; $display("MISMATCH t=%0t %s", $time, m); end end

module watch_interval_timer_tb;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   localparam logic [17:0] A_TCS  = `WIT_IDX_TCS << 2;
   localparam logic [17:0] A_WMC  = `WIT_IDX_WMC << 2;
   localparam logic [17:0] A_STAT = `WIT_IDX_STAT << 2;
   localparam logic [17:0] A_CLR  = `WIT_IDX_CLR << 2;
   localparam logic [17:0] A_EN   = `WIT_IDX_EN << 2;
   localparam logic [17:0] A_BIT  = `WIT_IDX_BIT << 2;
   logic        pclk, presetn, psel, penable, pwrite;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   logic        pready, pslverr, er;
   logic        osc_tick, sub_tick, osc_mode_select;
   logic        irq, wake_req_q, interval_irq_q;
   int          fail_count = 0;
   int          n_tests = 0;
   int          n;

   wit_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .osc_tick(osc_tick),
      .sub_tick(sub_tick), .osc_mode_select(osc_mode_select),
      .irq(irq), .wake_req_q(wake_req_q),
      .interval_irq_q(interval_irq_q));

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // ---------------------------------------------------------------
   // Bus and pulse helpers
   // ---------------------------------------------------------------
   task automatic apb(input logic w, input logic [17:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      `CHK(pready, 1'b1, "no ready")
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [17:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'h1);
   endtask

   task automatic rdc(input logic [17:0] a, input logic [7:0] e,
                      input string m);
      apb(1'b0, a, 32'h0, 4'h0);
      `CHK(rd[7:0], e, m)
   endtask

   // Cycles until the chosen event pulse, capped at lim
   task automatic pulse(input logic sel, input int lim, output int c);
      c = 0;
      do begin
         @(posedge pclk);
         #1;
         c++;
      end while ((sel ? interval_irq_q : wake_req_q) !== 1'b1
                 && c < lim);
   endtask

   task automatic gap(input logic sel, input int lim, output int c);
      pulse(sel, lim, c);
      pulse(sel, lim, c);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      rdc(A_TCS, `WIT_TCS_RST, "tcs reset");
      rdc(A_WMC, `WIT_WMC_RST, "wmc reset");
      rdc(A_STAT, 8'h00, "stat reset");
      rdc(A_EN, 8'h00, "en reset");
      `CHK(irq, 1'b0, "irq reset")
      $display("test reset done");
   endtask

   task automatic t_regs;
      apb(1'b1, A_TCS, 32'h0000_00ff, 4'h0);
      rdc(A_TCS, 8'h00, "tcs lane off");
      wr(A_TCS, 32'h0000_00ff);
      rdc(A_TCS, `WIT_TCS_MASK, "tcs byte");
      wr(A_BIT, 32'h0000_0009);
      rdc(A_WMC, 8'h02, "wmc bit set");
      wr(A_BIT, 32'h0000_0001);
      rdc(A_WMC, 8'h00, "wmc bit clr");
      rdc(A_CLR, 8'h00, "clr reads 0");
      apb(1'b0, 18'h3fd00, 32'h0, 4'h0);
      `CHK({er, rd}, 33'h1_0000_0000, "unmapped")
      apb(1'b1, 18'h3fd00, 32'h0000_00ff, 4'h1);
      `CHK(er, 1'b1, "unmapped write")
      // Timer is stopped here, so the source may change
      wr(A_TCS, 32'h0000_0010);
      $display("test regs done");
   endtask

   task automatic t_ival;
      int c;
      for (c = 0; c < 6; c++) begin
         wr(A_WMC, 32'(c << 4) | 32'h2);
         gap(1'b1, 2000, n);
         `CHK(n, 1 << (c + 4), "interval gap")
      end
      wr(A_WMC, 32'h62);
      pulse(1'b1, 600, n);
      `CHK(n, 600, "code 110 silent")
      wr(A_WMC, 32'h0);
      pulse(1'b1, 600, n);
      `CHK(n, 600, "prescaler stop")
      $display("test interval done");
   endtask

   task automatic t_fast;
      wr(A_WMC, 32'h03);
      gap(1'b0, 200, n);
      `CHK(n, 32, "fast gap")
      wr(A_EN, 32'h1);
      #1;
      `CHK(irq, 1'b1, "irq on")
      rdc(A_STAT, 8'h03, "stat both");
      wr(A_EN, 32'h0);
      #1;
      `CHK(irq, 1'b0, "irq masked")
      wr(A_WMC, 32'h0);
      wr(A_CLR, 32'h3);
      rdc(A_STAT, 8'h00, "stat cleared");
      $display("test fast done");
   endtask

   task automatic t_flag;
      wr(A_WMC, 32'h5e);
      gap(1'b0, 9000, n);
      `CHK(n, 8192, "flag 2^13")
      pulse(1'b1, 600, n);
      `CHK(n <= 512, 1'b1, "ival alongside")
      wr(A_WMC, 32'h56);
      gap(1'b0, 17000, n);
      `CHK(n, 16384, "flag 2^14")
      $display("test flag done");
   endtask

   task automatic t_restart;
      wr(A_WMC, 32'h5a);
      pulse(1'b0, 8300, n);
      `CHK(n, 8300, "counter stopped")
      wr(A_WMC, 32'h5e);
      pulse(1'b0, 9000, n);
      `CHK(n >= 7679 && n <= 8193, 1'b1, "restart")
      $display("test restart done");
   endtask

   task automatic t_src;
      wr(A_WMC, 32'h0);
      wr(A_TCS, 32'h0);
      osc_mode_select <= 1'b1;
      wr(A_WMC, 32'h02);
      gap(1'b1, 5000, n);
      `CHK(n, 2048, "osc full")
      wr(A_WMC, 32'h0);
      osc_mode_select <= 1'b0;
      wr(A_WMC, 32'h02);
      gap(1'b1, 9000, n);
      `CHK(n, 4096, "osc half")
      $display("test source done");
   endtask

   // ---------------------------------------------------------------
   // Sequence, watchdog and verdict
   // ---------------------------------------------------------------
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (95000) @(posedge pclk);
      fail_count++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      end_of_test();
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 18'h0;
      pwdata = 32'h0;
      pstrb = 4'h0;
      osc_tick = 1'b1;
      sub_tick = 1'b1;
      osc_mode_select = 1'b1;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_regs();
      t_ival();
      t_fast();
      t_flag();
      t_restart();
      t_src();
      end_of_test();
   end
endmodule
